// >>> verilog/relay_qual_cfg.svh
// constants for the relay pulse qualifier timer
`ifndef RELAY_QUAL_CFG_SVH
`define RELAY_QUAL_CFG_SVH
// ***********************************
// timebase
// ***********************************
`define RQ_CLK_PERIOD_NS 10
// ***********************************
// build-time timing, with legal ranges
// ***********************************
`define RQ_QUAL_TIME_US 15000
`define RQ_QUAL_MIN_US 128
`define RQ_QUAL_MAX_US 20000
`define RQ_MAX_TIME_US 150000
`define RQ_MAX_MIN_US 1000
`define RQ_MAX_MAX_US 350000
// least time rounds up, longest time rounds down
`define RQ_QUAL_CYCLES \
  ((`RQ_QUAL_TIME_US * 1000 + `RQ_CLK_PERIOD_NS - 1) / `RQ_CLK_PERIOD_NS)
`define RQ_MAX_CYCLES ((`RQ_MAX_TIME_US * 1000) / `RQ_CLK_PERIOD_NS)
// ***********************************
// register map
// ***********************************
`define RQ_CTRL_OFFS 12'h000
`define RQ_STAT_OFFS 12'h004
`define RQ_CTRL_EN_BIT 0
`define RQ_CTRL_FIXED_BIT 1
`define RQ_CTRL_LOCK_BIT 2
`define RQ_CTRL_TSD_BIT 3
`define RQ_CTRL_RESET 4'h0
`endif

// >>> verilog/relay_qual_pkg.sv
// types for the relay pulse qualifier timer
package relay_qual_pkg;
  typedef enum logic {ST_IDLE, ST_DRIVE} drive_state_e;
  typedef logic [31:0] count_t;
endpackage

// >>> verilog/relay_pulse_qualifier_timer.sv
// dual-channel command qualifier and coil pulse timer with apb control
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "relay_qual_cfg.svh"

// Functional notes
// - a command counts only after its input stayed high longer than qualify_time; shorter pulses are dropped.
// - every drive pulse ends when it reaches max_on_time, even if the input stays high.
// - in copy mode the drive lasts as long as the command pulse, capped at max_on_time.
// - in fixed mode the drive lasts exactly max_on_time after any qualified command.
// - the output mode changes neither qualification nor the max_on_time cap.
// - qualify_time is a build-time constant between 128 us and 20 ms.
// - max_on_time is a build-time constant between 1 ms and 350 ms.
// - the drive pulse starts when qualification completes, qualify_time after the rising edge.
// - qualification starts only on a rising edge; a level held high never starts a command.
// - while one channel drives, commands on the other input are discarded.
// - if both inputs qualify together, or one qualifies while the other is pending and the other then qualifies as well, no pulse is issued.
// - enable low, supply_lockout or thermal_shutdown stops all operation; the two indications beat enable.
module relay_pulse_qualifier_timer
  import relay_qual_pkg::*;
#(
  parameter count_t QUAL_CYCLES = `RQ_QUAL_CYCLES,
  parameter count_t MAX_CYCLES = `RQ_MAX_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // command inputs
  input wire logic coil_cmd_a,
  input wire logic coil_cmd_b,
  // open-drain coil drives
  input wire logic coil_drive_a_in,
  output logic coil_drive_a_out,
  output logic coil_drive_a_oe,
  input wire logic coil_drive_b_in,
  output logic coil_drive_b_out,
  output logic coil_drive_b_oe
);

  // ***********************************
  // pin synchronisers
  // ***********************************
  logic [1:0] cmd_pin;
  logic [1:0] pad_pin;
  logic [1:0] cmd_s1_reg;
  logic [1:0] cmd_s2_reg;
  logic [1:0] cmd_d_reg;
  logic [1:0] pad_s1_reg;
  logic [1:0] pad_s2_reg;
  logic [1:0] rise;

  assign cmd_pin = {coil_cmd_b, coil_cmd_a};
  assign pad_pin = {coil_drive_b_in, coil_drive_a_in};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmd_s1_reg[g] <= 1'b0;
          cmd_s2_reg[g] <= 1'b0;
          cmd_d_reg[g] <= 1'b0;
          pad_s1_reg[g] <= 1'b0;
          pad_s2_reg[g] <= 1'b0;
        end else begin
          cmd_s1_reg[g] <= cmd_pin[g];
          cmd_s2_reg[g] <= cmd_s1_reg[g];
          cmd_d_reg[g] <= cmd_s2_reg[g];
          pad_s1_reg[g] <= pad_pin[g];
          pad_s2_reg[g] <= pad_s1_reg[g];
        end
      end
      // edge, not level: a stuck-high source never fires
      assign rise[g] = cmd_s2_reg[g] & ~cmd_d_reg[g];
    end
  endgenerate

  // ***********************************
  // state
  // ***********************************
  drive_state_e state_reg, state_next;
  logic ch_reg, ch_next;
  logic [1:0] qact_reg, qact_next;
  logic [1:0] qdone_reg, qdone_next;
  logic [1:0] fell_reg, fell_next;
  count_t wcnt_reg [2];
  count_t wcnt_next [2];
  count_t dcnt_reg, dcnt_next;
  logic [1:0] oe_reg, oe_next;
  logic [3:0] ctrl_reg, ctrl_next;
  logic [31:0] prdata_reg, prdata_next;
  logic run;
  logic fixed_mode;
  logic apb_setup;
  logic apb_access;
  logic apb_hit;
  logic drive_end;

  // protection indications override enable
  assign run = ctrl_reg[`RQ_CTRL_EN_BIT] & ~ctrl_reg[`RQ_CTRL_LOCK_BIT]
             & ~ctrl_reg[`RQ_CTRL_TSD_BIT];
  assign fixed_mode = ctrl_reg[`RQ_CTRL_FIXED_BIT];

  // ***********************************
  // qualifier and pulse timer
  // ***********************************
  always_comb begin
    state_next = state_reg;
    ch_next = ch_reg;
    qact_next = qact_reg;
    qdone_next = qdone_reg;
    fell_next = fell_reg;
    wcnt_next = wcnt_reg;
    dcnt_next = dcnt_reg;
    drive_end = 1'b0;
    if (!run) begin
      state_next = ST_IDLE;
      qact_next = 2'b00;
      qdone_next = 2'b00;
      fell_next = 2'b00;
      dcnt_next = '0;
    end else if (state_reg == ST_IDLE) begin
      for (int i = 0; i < 2; i++) begin
        if (!qact_reg[i]) begin
          if (rise[i]) begin
            qact_next[i] = 1'b1;
            wcnt_next[i] = count_t'(1);
            fell_next[i] = 1'b0;
            qdone_next[i] = 1'b0;
          end
        end else if (!cmd_s2_reg[i]) begin
          // short pulse: dropped without a trace
          qact_next[i] = 1'b0;
          qdone_next[i] = 1'b0;
        end else begin
          if (wcnt_reg[i] < MAX_CYCLES) begin
            wcnt_next[i] = wcnt_reg[i] + count_t'(1);
          end
          if (wcnt_reg[i] >= QUAL_CYCLES) begin
            qdone_next[i] = 1'b1;
          end
        end
      end
      if (qdone_reg == 2'b11) begin
        qact_next = 2'b00;
        qdone_next = 2'b00;
      end else begin
        for (int i = 0; i < 2; i++) begin
          // other side still qualifying: hold the result pending
          if (qdone_reg[i] && !qact_reg[1 - i]) begin
            state_next = ST_DRIVE;
            ch_next = i[0];
            dcnt_next = '0;
            qact_next = 2'b00;
            qdone_next = 2'b00;
          end
        end
      end
    end else begin
      // other input is not looked at while driving
      if (!cmd_s2_reg[ch_reg]) begin
        fell_next[ch_reg] = 1'b1;
      end else if (!fell_reg[ch_reg] && wcnt_reg[ch_reg] < MAX_CYCLES) begin
        wcnt_next[ch_reg] = wcnt_reg[ch_reg] + count_t'(1);
      end
      dcnt_next = dcnt_reg + count_t'(1);
      if (dcnt_reg >= MAX_CYCLES - count_t'(1)) begin
        drive_end = 1'b1;
      end
      if (!fixed_mode && fell_reg[ch_reg] &&
          dcnt_reg + count_t'(1) >= wcnt_reg[ch_reg]) begin
        drive_end = 1'b1;
      end
      // fixed mode ends only on the cap
      if (drive_end) begin
        state_next = ST_IDLE;
        fell_next = 2'b00;
        dcnt_next = '0;
      end
    end
    oe_next[0] = (state_next == ST_DRIVE) && !ch_next;
    oe_next[1] = (state_next == ST_DRIVE) && ch_next;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      ch_reg <= 1'b0;
      qact_reg <= 2'b00;
      qdone_reg <= 2'b00;
      fell_reg <= 2'b00;
      wcnt_reg[0] <= '0;
      wcnt_reg[1] <= '0;
      dcnt_reg <= '0;
      oe_reg <= 2'b00;
    end else begin
      state_reg <= state_next;
      ch_reg <= ch_next;
      qact_reg <= qact_next;
      qdone_reg <= qdone_next;
      fell_reg <= fell_next;
      wcnt_reg <= wcnt_next;
      dcnt_reg <= dcnt_next;
      oe_reg <= oe_next;
    end
  end

  // drain only pulls low; the pad is released otherwise
  assign coil_drive_a_out = 1'b0;
  assign coil_drive_b_out = 1'b0;
  assign coil_drive_a_oe = oe_reg[0];
  assign coil_drive_b_oe = oe_reg[1];

  // ***********************************
  // apb registers
  // ***********************************
  assign apb_setup = psel & ~penable;
  assign apb_access = psel & penable;
  assign apb_hit = (paddr == `RQ_CTRL_OFFS) || (paddr == `RQ_STAT_OFFS);

  always_comb begin
    ctrl_next = ctrl_reg;
    prdata_next = prdata_reg;
    if (apb_access && pwrite && paddr == `RQ_CTRL_OFFS) begin
      ctrl_next = pwdata[3:0];
    end
    // read data captured in setup so the access phase needs no wait
    if (apb_setup) begin
      prdata_next = 32'h0000_0000;
      if (paddr == `RQ_CTRL_OFFS) begin
        prdata_next = {28'h0000000, ctrl_reg};
      end else if (paddr == `RQ_STAT_OFFS) begin
        prdata_next = {23'h0, run, pad_s2_reg, cmd_s2_reg, qact_reg,
                       oe_reg};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `RQ_CTRL_RESET;
      prdata_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = apb_access & ~apb_hit;

  // ***********************************
  // assertions
  // ***********************************
  property p_drive_needs_qual;
    @(posedge pclk) disable iff (!presetn)
      $rose(oe_reg[0]) |-> $past(qdone_reg[0]) && !$past(qdone_reg[1]);
  endproperty
  a_drive_needs_qual: assert property (p_drive_needs_qual)
    else $error("drive a started without qualification");

  property p_max_cap;
    @(posedge pclk) disable iff (!presetn)
      (oe_reg != 2'b00) |-> (dcnt_reg < MAX_CYCLES);
  endproperty
  a_max_cap: assert property (p_max_cap)
    else $error("drive pulse exceeded max_on_time");

  property p_copy_end;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == ST_DRIVE && !fixed_mode && fell_reg[ch_reg] &&
       dcnt_reg + count_t'(1) >= wcnt_reg[ch_reg]) |=> (oe_reg == 2'b00);
  endproperty
  a_copy_end: assert property (p_copy_end)
    else $error("copy mode drive outlived command width");

  property p_fixed_hold;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == ST_DRIVE && fixed_mode && run &&
       dcnt_reg < MAX_CYCLES - count_t'(1) && !(apb_access && pwrite))
      |=> (state_reg == ST_DRIVE) && $stable(ch_reg);
  endproperty
  a_fixed_hold: assert property (p_fixed_hold)
    else $error("fixed mode drive ended before max_on_time");

  property p_start_on_qual;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == ST_IDLE && qdone_reg == 2'b10 && !qact_reg[0] && run &&
       !(apb_access && pwrite)) |=> (oe_reg == 2'b10);
  endproperty
  a_start_on_qual: assert property (p_start_on_qual)
    else $error("drive b did not start on qualification");

  property p_start_on_edge;
    @(posedge pclk) disable iff (!presetn)
      $rose(qact_reg[1]) |-> $past(rise[1]);
  endproperty
  a_start_on_edge: assert property (p_start_on_edge)
    else $error("qualification began without a rising edge");

  property p_other_ignored;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == ST_DRIVE) |-> (qact_reg == 2'b00) && (oe_reg != 2'b11);
  endproperty
  a_other_ignored: assert property (p_other_ignored)
    else $error("command accepted during a drive pulse");

  property p_xor;
    @(posedge pclk) disable iff (!presetn)
      (qdone_reg == 2'b11 && state_reg == ST_IDLE)
      |=> (oe_reg == 2'b00) ##1 (oe_reg == 2'b00);
  endproperty
  a_xor: assert property (p_xor)
    else $error("pulse issued after both inputs qualified");

  property p_disable;
    @(posedge pclk) disable iff (!presetn)
      !run |=> (oe_reg == 2'b00) && (qact_reg == 2'b00);
  endproperty
  a_disable: assert property (p_disable)
    else $error("activity while disabled");

endmodule

// >>> bench/cmd_host_model.sv
// host side model: drives the two command inputs, resolves the coil pads
`timescale 1ns/1ps
module cmd_host_model (
  // clock
  input wire logic pclk,
  // drive side of the device
  input wire logic oe_a,
  input wire logic out_a,
  input wire logic oe_b,
  input wire logic out_b,
  // command lines and resolved pads
  output logic cmd_a,
  output logic cmd_b,
  output wire logic pad_a,
  output wire logic pad_b
);
  // the inputs idle low, so start low
  initial begin
    cmd_a = 1'b0;
    cmd_b = 1'b0;
  end
  // coil pulls the pad up whenever the device lets go
  assign pad_a = (oe_a && !out_a) ? 1'b0 : 1'b1;
  assign pad_b = (oe_b && !out_b) ? 1'b0 : 1'b1;
  // automatic, so both channels can run at once
  task automatic drive(input int ch, input int dly, input int w);
    if (w > 0) begin
      repeat (dly) @(posedge pclk);
      if (ch == 0) cmd_a <= 1'b1;
      else cmd_b <= 1'b1;
      repeat (w) @(posedge pclk);
      if (ch == 0) cmd_a <= 1'b0;
      else cmd_b <= 1'b0;
    end
  endtask
endmodule

// >>> bench/relay_pulse_qualifier_timer_tb.sv
// self-checking bench for the relay pulse qualifier timer
`timescale 1ns/1ps
`include "relay_qual_cfg.svh"
module relay_pulse_qualifier_timer_tb;
  import relay_qual_pkg::*;
  localparam int QUAL = 20;
  localparam int MAX = 100;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cmd_a, cmd_b, pad_a, pad_b;
  logic oe_a, oe_b, out_a, out_b;
  logic [1:0] cmd_v, oe_v, pad_v;
  logic [31:0] dis[4] = '{32'h0, 32'h5, 32'h9, 32'hd};
  assign cmd_v = {cmd_b, cmd_a};
  assign oe_v = {oe_b, oe_a};
  assign pad_v = {pad_b, pad_a};
  logic [31:0] rd;
  logic er;
  logic [31:0] seed = 32'hf24a;
  logic [1:0] cp = 2'b00;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int run[2], np[2], wd[2], dl[2], rs[2];
  int w;
  always #5 pclk = ~pclk;
  relay_pulse_qualifier_timer #(.QUAL_CYCLES(QUAL), .MAX_CYCLES(MAX))
    relay_pulse_qualifier_timer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .coil_cmd_a(cmd_a),
    .coil_cmd_b(cmd_b), .coil_drive_a_in(pad_a), .coil_drive_a_out(out_a),
    .coil_drive_a_oe(oe_a), .coil_drive_b_in(pad_b),
    .coil_drive_b_out(out_b), .coil_drive_b_oe(oe_b));
  cmd_host_model cmd_host_model_inst (
    .pclk(pclk), .oe_a(oe_a), .out_a(out_a), .oe_b(oe_b), .out_b(out_b),
    .cmd_a(cmd_a), .cmd_b(cmd_b), .pad_a(pad_a), .pad_b(pad_b));
  // ***********************************
  // helpers
  // ***********************************
  task print_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task check(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
    end
  endtask
  function logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // sync and edge flops smear the copy width by a couple of cycles
  function int near(input int s, input int e, input int t);
    return (s >= e - t && s <= e + t) ? e : s;
  endfunction
  function int exp_w(input logic fixed, input int wi);
    return fixed ? MAX : (wi < MAX ? wi : MAX);
  endfunction
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task scen(input logic [31:0] c, input int wa, input int wb, input int db,
            input int ea, input int eb, input int ew);
    apb(1'b1, `RQ_CTRL_OFFS, c);
    np = '{0, 0};
    fork
      cmd_host_model_inst.drive(0, 0, wa);
      cmd_host_model_inst.drive(1, db, wb);
    join
    repeat (QUAL + MAX + 20) @(posedge pclk);
    check("pulses_a", np[0], ea);
    check("pulses_b", np[1], eb);
    if (ew >= 0) check("width", near(wd[ea ? 0 : 1], ew, 2), ew);
    if (ea > 0) check("delay", near(dl[0], QUAL + 4, 2), QUAL + 4);
  endtask
  // ***********************************
  // pulse monitor
  // ***********************************
  always @(posedge pclk) begin
    cyc++;
    for (int i = 0; i < 2; i++) begin
      if (cmd_v[i] && !cp[i]) rs[i] = cyc;
      if (oe_v[i] === 1'b1) begin
        if (run[i] == 0) begin
          dl[i] = cyc - rs[i];
          check("pad_low", pad_v[i], 1'b0);
        end
        run[i]++;
      end else if (run[i] != 0) begin
        np[i]++;
        wd[i] = run[i];
        run[i] = 0;
      end
    end
    cp = cmd_v;
  end
  initial begin
    repeat (90000) @(posedge pclk);
    miscompares++;
    print_verdict();
  end
  // ***********************************
  // main sequence
  // ***********************************
  initial begin
    run = '{0, 0};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `RQ_CTRL_OFFS, 32'h0);
    check("ctrl_reset", rd, 32'h0);
    apb(1'b1, `RQ_CTRL_OFFS, 32'hffffffff);
    apb(1'b0, `RQ_CTRL_OFFS, 32'h0);
    check("ctrl_rw", rd, 32'h0000000f);
    apb(1'b0, `RQ_STAT_OFFS, 32'h0);
    check("run_off", rd[8], 1'b0);
    apb(1'b1, 12'h008, 32'h5);
    check("unmapped_err", er, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    check("unmapped_rd", rd, 32'h0);
    apb(1'b1, `RQ_CTRL_OFFS, 32'h1);
    apb(1'b0, `RQ_STAT_OFFS, 32'h0);
    check("run_on", rd[8], 1'b1);
    for (int m = 0; m < 2; m++) begin
      seed = lfsr(seed);
      w = QUAL + 5 + int'(seed % 60);
      scen(m ? 32'h3 : 32'h1, QUAL - 5, 0, 0, 0, 0, -1);
      scen(m ? 32'h3 : 32'h1, QUAL + 3, 0, 0, 1, 0, exp_w(m, QUAL + 3));
      scen(m ? 32'h3 : 32'h1, w, 0, 0, 1, 0, exp_w(m, w));
      scen(m ? 32'h3 : 32'h1, 0, 300, 0, 0, 1, MAX);
    end
    scen(32'h1, 60, 40, QUAL + 20, 1, 0, 60);
    scen(32'h1, 40, 40, 0, 0, 0, -1);
    scen(32'h1, 40, 10, 5, 1, 0, 40);
    scen(32'h1, 40, 40, 10, 0, 0, -1);
    foreach (dis[k])
      scen(dis[k], 40, 0, 0, 0, 0, -1);
    print_verdict();
  end
endmodule
